// ### hw/mcurf_top.sv
// Contract
// - port 0 nibbles each input or drain
// - port 1 whole byte input or drain
// - port 2 per-line direction, optional drain
// - port 3 low inputs, high outputs fixed
// - port 3 gives interrupts, timer in/out
// - reset starts fetch at 000c
// - hold execution 150 ms after reset
// - 16-bit counter, 4 KB on chip
// - first 12 bytes hold six vectors
// - 12..4095 rom, 4096 up reserved
// - decode ports, 236 general, control block
// - 4-bit address joined with pointer
// - sixteen working groups of sixteen
// - e0..ef hidden from direct addressing
// - protect option blocks program memory loads
// - addresses 0..15 backed by expanded groups
// - pointer high nibble working, low expanded
// - only expanded group f implemented
// - clock pin carries undivided system clock
// - stop recovery config at f:0b
module mcurf_top
    import mcurf_pkg::*;
#(
    parameter bit ROM_PROTECT = 1'b0,       // mask option
    parameter int POR_WAIT    = POR_CYCLES  // shorten in simulation
)(
    // clock and reset
    input  logic           ref_clk_i,
    input  logic           rstn_i,
    // register access from core
    input  mcurf_reg_req_s reg_req_i,
    output logic [7:0]     reg_rdata_o,
    // program memory access from core
    input  mcurf_pm_req_s  pm_req_i,
    output logic           pm_valid_o,
    output mcurf_region_e  pm_region_o,
    output logic           pm_blocked_o,
    // start-up
    output logic [15:0]    fetch_pc_o,
    output logic           exec_enable_o,
    // port 0
    input  logic [7:0]     p0_i,
    output logic [7:0]     p0_o,
    output logic [7:0]     p0_oe_o,
    // port 1
    input  logic [7:0]     p1_i,
    output logic [7:0]     p1_o,
    output logic [7:0]     p1_oe_o,
    // port 2
    input  logic [7:0]     p2_i,
    output logic [7:0]     p2_o,
    output logic [7:0]     p2_oe_o,
    // port 3, fixed directions
    input  logic [3:0]     p3_i,
    output logic [3:0]     p3_o,
    // port 3 special functions
    input  logic           timer_output_line_i,
    output logic [3:0]     external_irq_inputs_o,
    output logic           timer_input_line_o,
    // clock out
    output logic           system_clock_output_o
);

    // effective address from mode and pointer
    function automatic logic [7:0] eff_addr(input mcurf_mode_e m, input logic [7:0] a,
                                            input logic [7:0] wgp);
        if (m == MD_WORKING) begin
            return {wgp[7:4], a[3:0]};
        end
        return a;
    endfunction

    // state
    logic [7:0]   gp_q [4:239];       // general purpose file
    logic [7:0]   gp_d [4:239];
    logic [7:0]   wgp_q, wgp_d;       // working_group_pointer
    logic [7:0]   p01m_q, p01m_d;     // port 0/1 mode
    logic [7:0]   p2dir_q, p2dir_d;   // port 2 direction
    logic [7:0]   p3c_q, p3c_d;       // port 3 functions
    logic [7:0]   lat_q [0:3];        // port output latches
    logic [7:0]   lat_d [0:3];
    logic [7:0]   smr_q, smr_d;       // stop_recovery_config
    logic [7:0]   sysb_q, sysb_d;     // second group f register
    logic [7:0]   rdata_q, rdata_d;
    logic [3:0]   irq_q, irq_d;
    logic         tin_q, tin_d;
    mcurf_state_e st_q, st_d;
    logic [20:0]  por_q, por_d;       // wait counter
    logic [7:0]   p3_lat_out;

    // decode helpers
    logic [7:0]   ea;
    logic         exp_sel;            // expanded group in window 0..15
    logic         exp_f;
    logic         unimpl;
    logic         ebank_hit;
    logic [7:0]   sync [0:3];
    logic [7:0]   p3_pin_o;
    logic [7:0]   p3_unused_oe;

    always_comb begin
        ea        = eff_addr(reg_req_i.mode, reg_req_i.addr, wgp_q);
        exp_sel   = (ea[7:4] == 4'h0) && (wgp_q[3:0] != 4'h0);
        exp_f     = exp_sel && (wgp_q[3:0] == EXP_GROUP_SYS);
        unimpl    = exp_sel && !exp_f;
        ebank_hit = (reg_req_i.mode == MD_DIRECT) && ea >= EBANK_FIRST && ea <= EBANK_LAST;
    end

    // register file next values
    always_comb begin
        gp_d    = gp_q;
        wgp_d   = wgp_q;
        p01m_d  = p01m_q;
        p2dir_d = p2dir_q;
        p3c_d   = p3c_q;
        lat_d   = lat_q;
        smr_d   = smr_q;
        sysb_d  = sysb_q;
        rdata_d = rdata_q;
        // writes
        if (reg_req_i.wr && !ebank_hit && !unimpl) begin
            if (exp_f) begin
                // group f shows its own registers only
                if (ea[3:0] == EXP_SMR) begin
                    smr_d = reg_req_i.wdata;
                end else if (ea[3:0] == EXP_SYSB) begin
                    sysb_d = reg_req_i.wdata;
                end
            end else if (ea <= PORT_LAST) begin
                lat_d[ea[1:0]] = reg_req_i.wdata;
            end else if (ea <= GP_LAST) begin
                gp_d[ea] = reg_req_i.wdata;
            end else begin
                case (ea)
                    ADDR_WGP:      wgp_d   = reg_req_i.wdata;
                    ADDR_P01_MODE: p01m_d  = reg_req_i.wdata;
                    ADDR_P2_DIR:   p2dir_d = reg_req_i.wdata;
                    ADDR_P3_CTRL:  p3c_d   = reg_req_i.wdata;
                    default:       wgp_d   = wgp_q;   // other control slots inert
                endcase
            end
        end
        // reads, answer one cycle later
        if (reg_req_i.rd) begin
            if (ebank_hit || unimpl) begin
                rdata_d = READ_FILL;
            end else if (exp_f) begin
                if (ea[3:0] == EXP_SMR) begin
                    rdata_d = smr_q;
                end else if (ea[3:0] == EXP_SYSB) begin
                    rdata_d = sysb_q;
                end else begin
                    rdata_d = READ_FILL;
                end
            end else if (ea <= PORT_LAST) begin
                // port lines read their synchronised pin level, never the latch; port 3 bits 7:4 read 0
                rdata_d = sync[ea[1:0]];
            end else if (ea <= GP_LAST) begin
                rdata_d = gp_q[ea];
            end else begin
                case (ea)
                    ADDR_WGP:      rdata_d = wgp_q;
                    ADDR_P01_MODE: rdata_d = p01m_q;
                    ADDR_P2_DIR:   rdata_d = p2dir_q;
                    ADDR_P3_CTRL:  rdata_d = p3c_q;
                    default:       rdata_d = READ_FILL;
                endcase
            end
        end
    end

    // port 3 functions and start-up sequencing
    always_comb begin
        irq_d = p3c_q[P3C_IRQ_EN] ? sync[3][3:0] : 4'h0;
        tin_d = p3c_q[P3C_TIN_EN] & sync[3][P3_TIN_BIT];
        p3_lat_out = lat_q[3];
        if (p3c_q[P3C_TIMER_OUTPUT_LINE_EN]) begin
            p3_lat_out[P3_TIMER_OUTPUT_LINE_BIT] = timer_output_line_i;
        end
        st_d  = st_q;
        por_d = por_q;
        case (st_q)
            ST_POR: begin
                // hold off execution until the wait runs out
                if (por_q >= 21'(POR_WAIT - 1)) begin
                    st_d = ST_RUN;
                end else begin
                    por_d = por_q + 21'd1;
                end
            end
            ST_RUN:  st_d = ST_RUN;
            default: st_d = ST_POR;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 4; i <= 239; i++) begin
                gp_q[i] <= 8'h00;
            end
            for (int i = 0; i < 4; i++) begin
                lat_q[i] <= RST_PORT_OUT;
            end
            wgp_q   <= RST_WGP;
            p01m_q  <= RST_CTRL;
            p2dir_q <= RST_CTRL;
            p3c_q   <= RST_CTRL;
            smr_q   <= RST_SMR;
            sysb_q  <= RST_SYSB;
            rdata_q <= 8'h00;
            irq_q   <= 4'h0;
            tin_q   <= 1'b0;
            st_q    <= ST_POR;
            por_q   <= 21'd0;
        end else begin
            gp_q    <= gp_d;
            lat_q   <= lat_d;
            wgp_q   <= wgp_d;
            p01m_q  <= p01m_d;
            p2dir_q <= p2dir_d;
            p3c_q   <= p3c_d;
            smr_q   <= smr_d;
            sysb_q  <= sysb_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
            tin_q   <= tin_d;
            st_q    <= st_d;
            por_q   <= por_d;
        end
    end

    // port 0: one drain enable per nibble
    mcurf_port_io u_p0 (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (p0_i),
        .pin_o     (p0_o),
        .pin_oe_o  (p0_oe_o),
        .latch_i   (lat_q[0]),
        .drive_i   ({{4{p01m_q[P01_P0HI_OUT]}}, {4{p01m_q[P01_P0LO_OUT]}}}),
        .drain_i   (8'hff),
        .sync_o    (sync[0])
    );

    // port 1: one enable for the byte
    mcurf_port_io u_p1 (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (p1_i),
        .pin_o     (p1_o),
        .pin_oe_o  (p1_oe_o),
        .latch_i   (lat_q[1]),
        .drive_i   ({8{p01m_q[P01_P1_OUT]}}),
        .drain_i   (8'hff),
        .sync_o    (sync[1])
    );

    // port 2: per-line direction, shared drain choice
    mcurf_port_io u_p2 (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (p2_i),
        .pin_o     (p2_o),
        .pin_oe_o  (p2_oe_o),
        .latch_i   (lat_q[2]),
        .drive_i   (p2dir_q),
        .drain_i   ({8{p01m_q[P01_P2_OD]}}),
        .sync_o    (sync[2])
    );

    // port 3: directions fixed, no control
    mcurf_port_io u_p3 (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     ({4'h0, p3_i}),
        .pin_o     (p3_pin_o),
        .pin_oe_o  (p3_unused_oe),
        .latch_i   (p3_lat_out),
        .drive_i   (8'hf0),
        .drain_i   (8'h00),
        .sync_o    (sync[3])
    );

    mcurf_pm_check #(
        .ROM_PROTECT (ROM_PROTECT)
    ) u_pm (
        .ref_clk_i    (ref_clk_i),
        .rstn_i       (rstn_i),
        .pm_req_i     (pm_req_i),
        .pm_valid_o   (pm_valid_o),
        .pm_region_o  (pm_region_o),
        .pm_blocked_o (pm_blocked_o)
    );

    // outputs
    assign reg_rdata_o           = rdata_q;
    assign p3_o                  = p3_pin_o[7:4];
    assign external_irq_inputs_o = irq_q;
    assign timer_input_line_o    = tin_q;
    assign exec_enable_o         = st_q[1];                      // run bit of the one-hot state flop
    assign fetch_pc_o            = PM_RESET_PC;
    // a flop cannot follow its own clock undivided, so the pin takes the clock
    assign system_clock_output_o = ref_clk_i;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_wgp_write;
        reg_req_i.wr && !ebank_hit && !unimpl && !exp_f && ea == 8'hfd;
    endsequence

    a_wgp_update: assert property (s_wgp_write |=> wgp_q == $past(reg_req_i.wdata))
        else $error("pointer write lost");
    a_ebank_fill: assert property (reg_req_i.rd && reg_req_i.mode == MD_DIRECT && reg_req_i.addr[7:4] == 4'he
        |=> reg_rdata_o == 8'hff) else $error("direct read reached e bank");
    a_unimpl_inert: assert property (reg_req_i.wr && unimpl |=> $stable(smr_q) && $stable(sysb_q)
        && $stable(lat_q[0])) else $error("unimplemented group stored data");
    a_smr_write: assert property (reg_req_i.wr && wgp_q[3:0] == 4'hf && ea == 8'h0b
        |=> smr_q == $past(reg_req_i.wdata)) else $error("smr write lost");
    a_working_addr: assert property (reg_req_i.wr && reg_req_i.mode == MD_WORKING && wgp_q[7:4] == 4'he
        |=> gp_q[{4'he, $past(reg_req_i.addr[3:0])}] == $past(reg_req_i.wdata)) else $error("working write lost");
    a_irq_gate: assert property (!p3c_q[P3C_IRQ_EN] |=> external_irq_inputs_o == 4'h0)
        else $error("irq passed while disabled");
    a_p1_whole: assert property (!p01m_q[P01_P1_OUT] [*2] |-> p1_oe_o == 8'h00)
        else $error("port 1 driven while input");
    a_p0_drain: assert property ((p0_oe_o & p0_o) == 8'h00
        && (p0_oe_o[3:0] == 4'h0 || $past(p01m_q[P01_P0LO_OUT]))
        && (p0_oe_o[7:4] == 4'h0 || $past(p01m_q[P01_P0HI_OUT])))
        else $error("port 0 nibble driven against its mode");
    a_por_hold: assert property ($rose(exec_enable_o) |-> $past(por_q) == 21'(POR_WAIT - 1))
        else $error("execution started early");
    // port 3 enables never move once out of reset
    a_p3_fixed: assert property ($past(rstn_i) |-> p3_unused_oe == 8'hf0)
        else $error("port 3 direction changed");

endmodule

// ### hw/mcurf_pkg.sv
package mcurf_pkg;

    // register space layout
    localparam logic [7:0] PORT_LAST    = 8'h03;  // ports 0..3
    localparam logic [7:0] GP_FIRST     = 8'h04;  // general purpose start
    localparam logic [7:0] GP_LAST      = 8'hef;  // general purpose end
    localparam logic [7:0] EBANK_FIRST  = 8'he0;  // bank hidden from direct mode
    localparam logic [7:0] EBANK_LAST   = 8'hef;
    localparam logic [7:0] CTRL_FIRST   = 8'hf0;  // control and status start

    // control registers inside f0..ff
    localparam logic [7:0] ADDR_P2_DIR  = 8'hf6;  // port 2 per-line direction
    localparam logic [7:0] ADDR_P3_CTRL = 8'hf7;  // port 3 function enables
    localparam logic [7:0] ADDR_P01_MODE = 8'hf8; // port 0/1 mode, port 2 drain
    localparam logic [7:0] ADDR_WGP     = 8'hfd;  // working_group_pointer

    // expanded group f registers, low nibble offsets
    localparam logic [3:0] EXP_GROUP_SYS = 4'hf;
    localparam logic [3:0] EXP_SMR      = 4'hb;   // stop_recovery_config
    localparam logic [3:0] EXP_SYSB     = 4'hf;   // second system config

    // field positions
    localparam int P01_P0LO_OUT = 0;  // port 0 low nibble drains
    localparam int P01_P0HI_OUT = 1;  // port 0 high nibble drains
    localparam int P01_P1_OUT   = 2;  // port 1 whole byte drains
    localparam int P01_P2_OD    = 3;  // port 2 outputs open-drain
    localparam int P3C_IRQ_EN   = 0;  // p30..p33 as interrupt requests
    localparam int P3C_TIN_EN   = 1;  // p31 as timer input
    localparam int P3C_TIMER_OUTPUT_LINE_EN  = 2;  // p36 carries timer output
    localparam int P3_TIN_BIT   = 1;
    localparam int P3_TIMER_OUTPUT_LINE_BIT  = 6;

    // reset values
    localparam logic [7:0] RST_WGP      = 8'h00;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [7:0] RST_PORT_OUT = 8'hff;  // drains released
    localparam logic [7:0] RST_SMR      = 8'h20;
    localparam logic [7:0] RST_SYSB     = 8'h0f;
    localparam logic [7:0] READ_FILL    = 8'hff;  // unimplemented reads

    // program memory map
    localparam logic [15:0] PM_RESET_PC  = 16'h000c;
    localparam logic [15:0] PM_ROM_FIRST = 16'h000c; // below: six vectors
    localparam logic [15:0] PM_RESERVED  = 16'h1000; // 4096 and up

    // power-on wait
    localparam int POR_MS     = 150;
    localparam int CLK_HZ     = 10_000_000;
    localparam int POR_CYCLES = POR_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        MD_DIRECT   = 2'h0,
        MD_WORKING  = 2'h1,
        MD_INDIRECT = 2'h2
    } mcurf_mode_e;

    typedef enum logic [1:0] {
        ST_POR = 2'b01,
        ST_RUN = 2'b10
    } mcurf_state_e;

    typedef enum logic [2:0] {
        PR_VECTOR   = 3'b001,
        PR_ROM      = 3'b010,
        PR_RESERVED = 3'b100
    } mcurf_region_e;

    // one register access from the core
    typedef struct packed {
        logic        rd;
        logic        wr;
        mcurf_mode_e mode;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } mcurf_reg_req_s;

    // one program memory access from the core
    typedef struct packed {
        logic        req;
        logic        is_load;   // program_memory_load or _incr, external_memory_load or _incr
        logic [15:0] addr;
    } mcurf_pm_req_s;

endpackage

// ### hw/mcurf_port_io.sv
module mcurf_port_io
    import mcurf_pkg::*;
(
    // clock and reset
    input  logic       ref_clk_i,
    input  logic       rstn_i,
    // pin side
    input  logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    // core side
    input  logic [7:0] latch_i,   // output data latch
    input  logic [7:0] drive_i,   // line set as output
    input  logic [7:0] drain_i,   // output is open-drain
    output logic [7:0] sync_o     // pin level after two flops
);

    logic [7:0] meta_q;   // first stage, read only by second
    logic [7:0] sync_q;
    logic [7:0] out_q;
    logic [7:0] oe_q;
    logic [7:0] out_d;
    logic [7:0] oe_d;

    // drain lines drive low only, else release
    always_comb begin
        out_d = latch_i & ~drain_i;
        oe_d  = drive_i & (~drain_i | ~latch_i);
    end

    // synchroniser and registered drive
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
            out_q  <= 8'h00;
            oe_q   <= 8'h00;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            out_q  <= out_d;
            oe_q   <= oe_d;
        end
    end

    assign pin_o    = out_q;
    assign pin_oe_o = oe_q;
    assign sync_o   = sync_q;

endmodule

// ### hw/mcurf_pm_check.sv
module mcurf_pm_check
    import mcurf_pkg::*;
#(
    parameter bit ROM_PROTECT = 1'b0   // mask option
)(
    // clock and reset
    input  logic          ref_clk_i,
    input  logic          rstn_i,
    // request from core
    input  mcurf_pm_req_s pm_req_i,
    // answer, one cycle later
    output logic          pm_valid_o,
    output mcurf_region_e pm_region_o,
    output logic          pm_blocked_o
);

    logic          valid_q;
    logic          valid_d;
    mcurf_region_e region_q;
    mcurf_region_e region_d;
    logic          block_q;
    logic          block_d;

    // map decode and dump protection
    always_comb begin
        valid_d = pm_req_i.req;
        if (pm_req_i.addr >= PM_RESERVED) begin
            region_d = PR_RESERVED;
        end else if (pm_req_i.addr < PM_ROM_FIRST) begin
            region_d = PR_VECTOR;
        end else begin
            region_d = PR_ROM;
        end
        // loads blocked in every mode when the option is fitted
        block_d = pm_req_i.req & pm_req_i.is_load & ROM_PROTECT;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            valid_q  <= 1'b0;
            region_q <= PR_VECTOR;
            block_q  <= 1'b0;
        end else begin
            valid_q  <= valid_d;
            region_q <= region_d;
            block_q  <= block_d;
        end
    end

    assign pm_valid_o   = valid_q;
    assign pm_region_o  = region_q;
    assign pm_blocked_o = block_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    a_pm_reserved_map: assert property (pm_req_i.req && pm_req_i.addr >= 16'h1000 |=>
        pm_region_o == PR_RESERVED && pm_valid_o) else $error("reserved address not flagged");
    a_pm_vector_map: assert property (pm_req_i.req && pm_req_i.addr < 16'd12 |=>
        pm_region_o == PR_VECTOR) else $error("vector area not flagged");
    a_pm_load_block: assert property (pm_req_i.req && pm_req_i.is_load |=>
        pm_blocked_o == ROM_PROTECT) else $error("load protect wrong");

endmodule

// ### sim/mcurf_pins_model.sv
module mcurf_pins_model (
    // block side of ports 0..2
    input  wire logic [23:0] drv_i,   // level the block drives
    input  wire logic [23:0] oe_i,    // high while the block drives
    // keyboard side
    input  wire logic [23:0] key_i,   // pressed key pulls low
    output wire logic [23:0] line_o   // resolved wire level
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-ups lift released lines, so no stale level is ever seen
    assign line_o = ~key_i & (~oe_i | drv_i);
endmodule

// ### sim/mcurf_top_test.sv
module mcurf_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mcurf_pkg::*;
    localparam int WAIT = 20;                  // shortened power-on wait
    logic           ref_clk_i, rstn_i, timer_output_line, valid, blocked, exec_en, timer_input_line, sclk, rd_seen;
    mcurf_reg_req_s req;                       // register access
    mcurf_pm_req_s  pm;                        // program memory access
    mcurf_region_e  region;
    logic [7:0]     rdata, p0_o, p0_oe, p1_o, p1_oe, p2_o, p2_oe, key_q;
    logic [23:0]    pins;                      // resolved port lines
    logic [3:0]     p3_i, p3_o, irq;
    logic [15:0]    pc;
    logic [15:0]    rq[$];                     // expected read data
    logic [15:0]    pq[$];                     // expected region and block
    logic [15:0]    pa[5] = '{16'h0000, 16'h000b, 16'h000c, 16'h0fff, 16'h1000};
    logic [2:0]     pr[5] = '{3'b001, 3'b001, 3'b010, 3'b010, 3'b100};
    logic           ld[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    int             fails, samples_checked;

    mcurf_top #(.ROM_PROTECT(1'b1), .POR_WAIT(WAIT)) u_mcurf_top (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .pm_req_i(pm), .pm_valid_o(valid), .pm_region_o(region), .pm_blocked_o(blocked),
        .fetch_pc_o(pc), .exec_enable_o(exec_en),
        .p0_i(pins[7:0]), .p0_o(p0_o), .p0_oe_o(p0_oe),
        .p1_i(pins[15:8]), .p1_o(p1_o), .p1_oe_o(p1_oe),
        .p2_i(pins[23:16]), .p2_o(p2_o), .p2_oe_o(p2_oe),
        .p3_i(p3_i), .p3_o(p3_o), .timer_output_line_i(timer_output_line),
        .external_irq_inputs_o(irq), .timer_input_line_o(timer_input_line), .system_clock_output_o(sclk));

    mcurf_pins_model u_mcurf_pins_model (.drv_i({p2_o, p1_o, p0_o}), .oe_i({p2_oe, p1_oe, p0_oe}),
        .key_i({16'h0, key_q}), .line_o(pins));

    // one compare for every kind of result
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one register cycle; a read carries its expected value in d
    task automatic acc(logic rd, logic wr, mcurf_mode_e md, logic [7:0] a, logic [7:0] d);
        @(negedge ref_clk_i);
        req = '{rd, wr, md, a, rd ? 8'h00 : d};
        if (rd) rq.push_back({8'h00, d});
    endtask

    task automatic idle(int n);
        @(negedge ref_clk_i);
        req = '0;
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // clock, 100 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // watchdog, about forty times the fifty or so cycles needed
    initial begin
        #200000;
        fails++;
        end_sim();
    end

    // result watcher: read data one cycle after rd, pm answer on valid
    always @(posedge ref_clk_i) rd_seen <= req.rd;
    always @(negedge ref_clk_i) begin
        if (rd_seen) chk("read data", rq.pop_front(), {8'h00, rdata});
        if (valid) chk("pm answer", pq.pop_front(), {12'h0, region, blocked});
    end

    initial begin
        logic [7:0] v;
        void'($urandom(7992));
        rstn_i = 1'b0; req = '0; pm = '0; p3_i = 4'h0; timer_output_line = 1'b0; key_q = 8'h00;
        repeat (3) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        chk("start pc", PM_RESET_PC, pc);
        chk("exec early", 16'h0, {15'h0, exec_en});
        v = 8'($urandom);
        acc(1, 0, MD_DIRECT, ADDR_WGP, RST_WGP);
        acc(0, 1, MD_DIRECT, 8'h32, v);
        acc(0, 1, MD_DIRECT, ADDR_WGP, 8'h35);
        acc(1, 0, MD_WORKING, 8'h02, v);
        acc(1, 0, MD_INDIRECT, 8'h32, v);
        acc(0, 1, MD_DIRECT, ADDR_WGP, 8'he0);
        acc(0, 1, MD_WORKING, 8'h05, ~v);
        acc(0, 1, MD_DIRECT, 8'he5, v);
        acc(1, 0, MD_WORKING, 8'h05, ~v);
        acc(1, 0, MD_DIRECT, 8'he5, READ_FILL);
        acc(0, 1, MD_DIRECT, ADDR_WGP, 8'h0f);
        acc(1, 0, MD_DIRECT, 8'h0b, RST_SMR);
        acc(1, 0, MD_DIRECT, 8'h0f, RST_SYSB);
        acc(1, 0, MD_DIRECT, 8'h05, READ_FILL);
        acc(0, 1, MD_DIRECT, 8'h0b, v);
        acc(1, 0, MD_DIRECT, 8'h0b, v);
        acc(0, 1, MD_DIRECT, ADDR_WGP, 8'h03);
        acc(0, 1, MD_DIRECT, 8'h05, v);
        acc(1, 0, MD_DIRECT, 8'h05, READ_FILL);
        acc(0, 1, MD_DIRECT, ADDR_WGP, 8'h00);
        acc(1, 0, MD_DIRECT, 8'h05, 8'h00);
        acc(1, 0, MD_DIRECT, 8'hf0, READ_FILL);
        // port set-up: keys on port 0 high nibble, random irq lines
        key_q = 8'($urandom) & 8'hf0;
        p3_i = 4'($urandom);
        timer_output_line = 1'($urandom);
        acc(0, 1, MD_DIRECT, ADDR_P2_DIR, 8'h0f);
        acc(0, 1, MD_DIRECT, ADDR_P01_MODE, 8'h05);
        acc(0, 1, MD_DIRECT, 8'h00, 8'h5a);
        acc(0, 1, MD_DIRECT, 8'h01, 8'h3c);
        acc(0, 1, MD_DIRECT, 8'h02, v);
        acc(0, 1, MD_DIRECT, 8'h03, 8'ha0);
        acc(0, 1, MD_DIRECT, ADDR_P3_CTRL, 8'h07);
        idle(6);
        #1;                                                 // let the clock pin follow the falling edge
        chk("p0 drive", 16'h0500, {p0_oe, p0_o});
        chk("p1 drive", 16'hc300, {p1_oe, p1_o});
        chk("p2 drive", {8'h0f, v & 8'h0f}, {p2_oe, p2_o & 8'h0f});
        chk("p3 out", {12'h0, 1'b1, timer_output_line, 2'b10}, {12'h0, p3_o});
        chk("p3 func", {11'h0, p3_i, p3_i[1]}, {11'h0, irq, timer_input_line});
        chk("exec late", 16'h1, {15'h0, exec_en});
        chk("clock low", 16'h0, {15'h0, sclk});
        acc(1, 0, MD_DIRECT, 8'h00, ~key_q & 8'hfa);
        @(posedge ref_clk_i);
        #1;
        chk("clock high", 16'h1, {15'h0, sclk});
        // program memory map, loads blocked by protect
        foreach (pa[i]) begin
            @(negedge ref_clk_i);
            req = '0;
            pm = '{1'b1, ld[i], pa[i]};
            pq.push_back({12'h0, pr[i], ld[i]});
        end
        @(negedge ref_clk_i);
        pm = '0;
        idle(3);
        chk("notes left", 16'h0, 16'(rq.size() + pq.size()));
        end_sim();
    end
endmodule
